// File: design/iprl_level_decode.sv
// decodes one 2-bit level field into a gated request and its level
`timescale 1ns/100ps
`default_nettype none
module iprl_level_decode (
   // level field and raw source request
   input wire logic [iprl_pkg::FLD_W-1:0] field,
   input wire logic src_req,
   // request towards arbitration
   output logic arb_req,
   output logic [iprl_pkg::FLD_W-1:0] arb_level
);
   import iprl_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // 00 disables; 01,10,11 mean levels 0,1,2
   always_comb begin
      arb_req = src_req && (field != LEVEL_DISABLED);
      if (field == LEVEL_DISABLED) begin
         arb_level = LEVEL_DISABLED;
      end else begin
         arb_level = field - 2'h1;
      end
   end

endmodule : iprl_level_decode
`default_nettype wire

// File: design/iprl_regs.sv
// priority level registers 2 to 4 with request gating and wake path
// What this block does
// - level field 00 disables its source; 00 is the reset value.
// - field 01, 10, 11 give priority levels 0, 1, 2.
// - reserved bits read zero and ignore writes.
// - reset clears all three priority registers, disabling every source.
// - second register: flash buffers empty, command done, fault at 15-10.
// - second register: pll unlocked bits 9-8, low voltage bits 7-6.
// - second register: pin b bits 3-2, pin a bits 1-0, 5-4 reserved.
// - third register: port groups d, e, f at bits 15-10.
// - third register: can fields at bits 9-2, bits 1-0 reserved.
// - fourth register: serial port fields 15-10, bits 9-6 reserved.
// - fourth register: port groups a, b, c at bits 5-0.
// - in low power, enabled-before-entry sources raise the wake request.
// - in low power both external pins act as low-level sensitive.
// - registers sit at arbiter base plus indices 2, 3 and 4.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module iprl_regs #(
   parameter int unsigned APB_AW = 12
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // peripheral requests, same clock, active high
   input wire logic [iprl_pkg::NUM_SRC-3:0] periph_req,
   // external pins, asynchronous, active low
   input wire logic external_pin_a_n,
   input wire logic external_pin_b_n,
   // low power mode from the system integration unit
   input wire logic low_power_mode,
   output logic wake_req,
   // towards priority arbitration
   output logic [iprl_pkg::NUM_SRC-1:0] arb_req,
   output logic [iprl_pkg::NUM_SRC*iprl_pkg::FLD_W-1:0] arb_level,
   input wire logic [iprl_pkg::NUM_SRC-1:0] arb_ack
);
   import iprl_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // declarations
   logic [REG_W-1:0] pri_fpp_r, pri_pdc_r, pri_spa_r;
   logic [1:0] pin_mode_r;
   logic [31:0] prdata_r;
   logic [2:0] pin_a_sync_r, pin_b_sync_r;
   logic pin_a_low_r, pin_b_low_r;
   logic pin_a_edge_r, pin_b_edge_r;
   logic lp_mode_d_r;
   logic [NUM_SRC-1:0] wake_mask_r;
   logic [NUM_SRC*FLD_W-1:0] fields;
   logic [NUM_SRC-1:0] src_req, wake_src, enabled;
   logic setup_ph, wr_acc;
   logic hit_fpp, hit_pdc, hit_spa, hit_mode, hit_pend, hit_any;
   logic pin_a_fall, pin_b_fall;

   ////////////////////////////////////////////////////////////////////////
   // functions
   // word index match; the low two address bits must be zero
   function automatic logic idx_hit(input logic [APB_AW-1:0] a,
                                    input logic [7:0] idx);
      idx_hit = (a[APB_AW-1:2] == (APB_AW-2)'(idx)) && (a[1:0] == 2'h0);
   endfunction : idx_hit
   // byte-lane merge then writable mask
   function automatic logic [REG_W-1:0] wr_merge(
      input logic [REG_W-1:0] old,
      input logic [31:0] wd,
      input logic [3:0] strb,
      input logic [REG_W-1:0] mask);
      logic [REG_W-1:0] lanes;
      lanes = {{8{strb[1]}}, {8{strb[0]}}};
      wr_merge = ((old & ~lanes) | (wd[REG_W-1:0] & lanes)) & mask;
   endfunction : wr_merge

   ////////////////////////////////////////////////////////////////////////
   // apb decode; zero wait states, error on unmapped words
   assign setup_ph = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   assign hit_fpp = idx_hit(paddr, IDX_PRIORITY_FLASH_POWER_PINS);
   assign hit_pdc = idx_hit(paddr, IDX_PRIORITY_PORTS_DEF_CAN);
   assign hit_spa = idx_hit(paddr, IDX_PRIORITY_SERIAL_PORTS_ABC);
   assign hit_mode = idx_hit(paddr, IDX_PIN_MODE);
   assign hit_pend = idx_hit(paddr, IDX_PENDING);
   assign hit_any = hit_fpp || hit_pdc || hit_spa || hit_mode || hit_pend;
   assign pready = 1'b1;
   // writes to the read-only pending word are refused too
   assign pslverr = psel && penable && (!hit_any || (pwrite && hit_pend));
   assign prdata = prdata_r;

   // read data captured in the setup cycle, reserved bits forced low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup_ph && !pwrite) begin
         if (hit_fpp) begin
            prdata_r <= {16'h0000, pri_fpp_r & MASK_FLASH_POWER_PINS};
         end else if (hit_pdc) begin
            prdata_r <= {16'h0000, pri_pdc_r & MASK_PORTS_DEF_CAN};
         end else if (hit_spa) begin
            prdata_r <= {16'h0000, pri_spa_r & MASK_SERIAL_PORTS_ABC};
         end else if (hit_mode) begin
            prdata_r <= {30'h0000_0000, pin_mode_r};
         end else if (hit_pend) begin
            prdata_r <= {12'h000, arb_req};
         end else begin
            prdata_r <= 32'h0000_0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // priority registers; whole register updates in one edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pri_fpp_r <= PRI_RESET;
         pri_pdc_r <= PRI_RESET;
         pri_spa_r <= PRI_RESET;
      end else if (wr_acc) begin
         if (hit_fpp) begin
            pri_fpp_r <= wr_merge(pri_fpp_r, pwdata, pstrb,
                                  MASK_FLASH_POWER_PINS);
         end
         if (hit_pdc) begin
            pri_pdc_r <= wr_merge(pri_pdc_r, pwdata, pstrb,
                                  MASK_PORTS_DEF_CAN);
         end
         if (hit_spa) begin
            pri_spa_r <= wr_merge(pri_spa_r, pwdata, pstrb,
                                  MASK_SERIAL_PORTS_ABC);
         end
      end
   end

   // pin sense: bit0 pin a, bit1 pin b; 1 selects falling edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_mode_r <= PIN_MODE_RESET;
      end else if (wr_acc && hit_mode && pstrb[0]) begin
         pin_mode_r <= pwdata[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // field gather into source order
   always_comb begin
      fields = '0;
      for (int i = 0; i < NUM_SRC; i++) begin
         case (SRC_REG[i])
            2: fields[i*FLD_W +: FLD_W] =
                  pri_fpp_r[SRC_LSB[i] +: FLD_W];
            3: fields[i*FLD_W +: FLD_W] =
                  pri_pdc_r[SRC_LSB[i] +: FLD_W];
            default: fields[i*FLD_W +: FLD_W] =
                  pri_spa_r[SRC_LSB[i] +: FLD_W];
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; a change counts once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_a_sync_r <= 3'h7;
         pin_b_sync_r <= 3'h7;
      end else begin
         pin_a_sync_r <= {pin_a_sync_r[1:0], external_pin_a_n};
         pin_b_sync_r <= {pin_b_sync_r[1:0], external_pin_b_n};
      end
   end

   // filtered pin levels, active when low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_a_low_r <= 1'b0;
         pin_b_low_r <= 1'b0;
      end else begin
         if (pin_a_sync_r[1] == pin_a_sync_r[2]) begin
            pin_a_low_r <= !pin_a_sync_r[2];
         end
         if (pin_b_sync_r[1] == pin_b_sync_r[2]) begin
            pin_b_low_r <= !pin_b_sync_r[2];
         end
      end
   end

   assign pin_a_fall = !pin_a_low_r && (pin_a_sync_r[1] == pin_a_sync_r[2])
                       && !pin_a_sync_r[2];
   assign pin_b_fall = !pin_b_low_r && (pin_b_sync_r[1] == pin_b_sync_r[2])
                       && !pin_b_sync_r[2];

   // edge latches; a new edge wins over the acknowledge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_a_edge_r <= 1'b0;
         pin_b_edge_r <= 1'b0;
      end else begin
         if (pin_a_fall) begin
            pin_a_edge_r <= 1'b1;
         end else if (arb_ack[SRC_PIN_A]) begin
            pin_a_edge_r <= 1'b0;
         end
         if (pin_b_fall) begin
            pin_b_edge_r <= 1'b1;
         end else if (arb_ack[SRC_PIN_B]) begin
            pin_b_edge_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // raw source vector; pins fall back to level sense in low power
   always_comb begin
      int unsigned j;
      j = 0;
      src_req = '0;
      wake_src = '0;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (i == SRC_PIN_A) begin
            src_req[i] = (low_power_mode || !pin_mode_r[0]) ?
                         pin_a_low_r : pin_a_edge_r;
            wake_src[i] = !external_pin_a_n;
         end else if (i == SRC_PIN_B) begin
            src_req[i] = (low_power_mode || !pin_mode_r[1]) ?
                         pin_b_low_r : pin_b_edge_r;
            wake_src[i] = !external_pin_b_n;
         end else begin
            src_req[i] = periph_req[j];
            wake_src[i] = periph_req[j];
            j = j + 1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-source gating and level tag
   genvar g;
   generate
      for (g = 0; g < NUM_SRC; g++) begin : g_src
         iprl_level_decode u_dec (
            .field(fields[g*FLD_W +: FLD_W]),
            .src_req(src_req[g]),
            .arb_req(arb_req[g]),
            .arb_level(arb_level[g*FLD_W +: FLD_W])
         );
         assign enabled[g] = fields[g*FLD_W +: FLD_W] != LEVEL_DISABLED;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // enable snapshot taken while still running, before low power starts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lp_mode_d_r <= 1'b0;
         wake_mask_r <= '0;
      end else begin
         lp_mode_d_r <= low_power_mode;
         if (!low_power_mode) begin
            wake_mask_r <= enabled;
         end
      end
   end

   // combinational on purpose: the clock is stopped while it matters,
   // so the pins reach it unsynchronised
   assign wake_req = low_power_mode && |(wake_src & wake_mask_r);

   ////////////////////////////////////////////////////////////////////////
   // checks
   logic [REG_W-1:0] exp_fpp_r;
   logic wr_fpp_d_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exp_fpp_r <= PRI_RESET;
         wr_fpp_d_r <= 1'b0;
      end else begin
         wr_fpp_d_r <= wr_acc && hit_fpp && (pstrb[1:0] == 2'h3);
         exp_fpp_r <= pwdata[REG_W-1:0] & MASK_FLASH_POWER_PINS;
      end
   end

   property p_reset_clear;
      @(posedge pclk) $rose(presetn) |->
         (pri_fpp_r == PRI_RESET) && (pri_pdc_r == PRI_RESET)
         && (pri_spa_r == PRI_RESET) && (arb_req == '0);
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("priority registers not clear after reset");
   property p_rsv_zero;
      @(posedge pclk) disable iff (!presetn)
         ((pri_fpp_r & ~MASK_FLASH_POWER_PINS) == '0)
         && ((pri_pdc_r & ~MASK_PORTS_DEF_CAN) == '0)
         && ((pri_spa_r & ~MASK_SERIAL_PORTS_ABC) == '0);
   endproperty
   a_rsv_zero: assert property (p_rsv_zero)
      else $error("reserved bit held a one");
   property p_disabled_quiet;
      @(posedge pclk) disable iff (!presetn)
         (fields[FLD_W-1:0] == LEVEL_DISABLED) |-> !arb_req[0];
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet)
      else $error("disabled source reached arbitration");
   property p_level_map;
      @(posedge pclk) disable iff (!presetn)
         (pri_spa_r[PORT_GROUP_C_LEVEL_LSB +: FLD_W] == 2'h3) |->
         (arb_level[(NUM_SRC-1)*FLD_W +: FLD_W] == 2'h2);
   endproperty
   a_level_map: assert property (p_level_map)
      else $error("field 11 did not give level 2");
   property p_write_next;
      @(posedge pclk) disable iff (!presetn)
         wr_fpp_d_r |-> (pri_fpp_r == exp_fpp_r);
   endproperty
   a_write_next: assert property (p_write_next)
      else $error("full write not seen on the next cycle");
   property p_field_place;
      @(posedge pclk) disable iff (!presetn)
         (periph_req[0] && wr_fpp_d_r && (exp_fpp_r[15:14] != 2'h0))
         |-> arb_req[0] && (arb_level[FLD_W-1:0] == exp_fpp_r[15:14] - 2'h1);
   endproperty
   a_field_place: assert property (p_field_place)
      else $error("flash buffers empty field misplaced");
   property p_read_back;
      @(posedge pclk) disable iff (!presetn)
         (setup_ph && !pwrite && hit_spa) ##1 (psel && penable) |->
         (prdata == {16'h0000, pri_spa_r});
   endproperty
   a_read_back: assert property (p_read_back)
      else $error("read of fourth register returned wrong data");
   // entry cycle: wake mask must hold the enables of the last running cycle
   property p_wake;
      @(posedge pclk) disable iff (!presetn)
         (low_power_mode && !lp_mode_d_r) |-> (wake_mask_r == $past(enabled));
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake mask not taken from the last running cycle");
   property p_pin_level_lp;
      @(posedge pclk) disable iff (!presetn)
         (low_power_mode && pin_a_low_r
          && (fields[SRC_PIN_A*FLD_W +: FLD_W] != LEVEL_DISABLED))
         |-> arb_req[SRC_PIN_A];
   endproperty
   a_pin_level_lp: assert property (p_pin_level_lp)
      else $error("pin a not level sensitive in low power");
   property p_gate;
      @(posedge pclk) disable iff (!presetn)
         arb_req[NUM_SRC-1] |-> periph_req[NUM_SRC-3]
         && (fields[(NUM_SRC-1)*FLD_W +: FLD_W] != LEVEL_DISABLED);
   endproperty
   a_gate: assert property (p_gate)
      else $error("request passed without source or level");
   c_write_fpp: cover property (@(posedge pclk) wr_acc && hit_fpp);
   c_read_pend: cover property (@(posedge pclk) setup_ph && hit_pend);
   c_wake: cover property (@(posedge pclk) wake_req);
   c_edge: cover property (@(posedge pclk) pin_a_edge_r && pin_mode_r[0]);

endmodule : iprl_regs
`default_nettype wire

// File: pkg/iprl_pkg.sv
// constants for the priority level registers 2 to 4 of the interrupt arbiter
package iprl_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_PRIORITY_FLASH_POWER_PINS = 8'h02;
   localparam logic [7:0] IDX_PRIORITY_PORTS_DEF_CAN = 8'h03;
   localparam logic [7:0] IDX_PRIORITY_SERIAL_PORTS_ABC = 8'h04;
   localparam logic [7:0] IDX_PIN_MODE = 8'h20;
   localparam logic [7:0] IDX_PENDING = 8'h21;

   ////////////////////////////////////////////////////////////////////////
   // widths, reset values and writable masks
   localparam int unsigned REG_W = 16;
   localparam int unsigned FLD_W = 2;
   localparam int unsigned NUM_SRC = 20;
   localparam logic [15:0] PRI_RESET = 16'h0000;
   localparam logic [15:0] MASK_FLASH_POWER_PINS = 16'hFFCF;
   localparam logic [15:0] MASK_PORTS_DEF_CAN = 16'hFFFC;
   localparam logic [15:0] MASK_SERIAL_PORTS_ABC = 16'hFC3F;
   localparam logic [1:0] PIN_MODE_RESET = 2'h0;
   localparam logic [1:0] LEVEL_DISABLED = 2'h0;

   ////////////////////////////////////////////////////////////////////////
   // field low bits within their register
   localparam int unsigned FLASH_BUFFERS_EMPTY_LEVEL_LSB = 14;
   localparam int unsigned FLASH_COMMAND_DONE_LEVEL_LSB = 12;
   localparam int unsigned FLASH_FAULT_LEVEL_LSB = 10;
   localparam int unsigned PLL_UNLOCKED_LEVEL_LSB = 8;
   localparam int unsigned LOW_VOLTAGE_LEVEL_LSB = 6;
   localparam int unsigned EXTERNAL_PIN_B_LEVEL_LSB = 2;
   localparam int unsigned EXTERNAL_PIN_A_LEVEL_LSB = 0;
   localparam int unsigned PORT_GROUP_D_LEVEL_LSB = 14;
   localparam int unsigned PORT_GROUP_E_LEVEL_LSB = 12;
   localparam int unsigned PORT_GROUP_F_LEVEL_LSB = 10;
   localparam int unsigned CAN_MESSAGE_BUFFER_LEVEL_LSB = 8;
   localparam int unsigned CAN_WAKEUP_LEVEL_LSB = 6;
   localparam int unsigned CAN_FAULT_LEVEL_LSB = 4;
   localparam int unsigned CAN_BUS_OFF_LEVEL_LSB = 2;
   localparam int unsigned SERIAL_PORT0_RECEIVE_LEVEL_LSB = 14;
   localparam int unsigned SERIAL_PORT1_TRANSMIT_LEVEL_LSB = 12;
   localparam int unsigned SERIAL_PORT1_RECEIVE_LEVEL_LSB = 10;
   localparam int unsigned PORT_GROUP_A_LEVEL_LSB = 4;
   localparam int unsigned PORT_GROUP_B_LEVEL_LSB = 2;
   localparam int unsigned PORT_GROUP_C_LEVEL_LSB = 0;

   // source slot of each field: register number and low bit
   localparam int unsigned SRC_REG [NUM_SRC] = '{2, 2, 2, 2, 2, 2, 2,
      3, 3, 3, 3, 3, 3, 3, 4, 4, 4, 4, 4, 4};
   localparam int unsigned SRC_LSB [NUM_SRC] = '{
      FLASH_BUFFERS_EMPTY_LEVEL_LSB, FLASH_COMMAND_DONE_LEVEL_LSB,
      FLASH_FAULT_LEVEL_LSB, PLL_UNLOCKED_LEVEL_LSB,
      LOW_VOLTAGE_LEVEL_LSB, EXTERNAL_PIN_B_LEVEL_LSB,
      EXTERNAL_PIN_A_LEVEL_LSB, PORT_GROUP_D_LEVEL_LSB,
      PORT_GROUP_E_LEVEL_LSB, PORT_GROUP_F_LEVEL_LSB,
      CAN_MESSAGE_BUFFER_LEVEL_LSB, CAN_WAKEUP_LEVEL_LSB,
      CAN_FAULT_LEVEL_LSB, CAN_BUS_OFF_LEVEL_LSB,
      SERIAL_PORT0_RECEIVE_LEVEL_LSB, SERIAL_PORT1_TRANSMIT_LEVEL_LSB,
      SERIAL_PORT1_RECEIVE_LEVEL_LSB, PORT_GROUP_A_LEVEL_LSB,
      PORT_GROUP_B_LEVEL_LSB, PORT_GROUP_C_LEVEL_LSB};
   localparam int unsigned SRC_PIN_B = 5;
   localparam int unsigned SRC_PIN_A = 6;

endpackage : iprl_pkg

// File: verif/iprl_src_model.sv
// model of the peripheral sources, external pins and core acknowledge
`timescale 1ns/100ps
`default_nettype none
module iprl_src_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // commanded source activity, in source order
   input wire logic [19:0] src_on,
   // requests and pins towards the block
   output logic [17:0] periph_req,
   output logic external_pin_a_n,
   output logic external_pin_b_n,
   // core side
   input wire logic [19:0] arb_req,
   output logic [19:0] arb_ack
);
   logic [19:0] seen_r;
   // peripherals skip the pin slots 5 and 6
   assign periph_req = {src_on[19:7], src_on[4:0]};
   // pins pulled up, so an inactive pin reads high
   assign external_pin_b_n = ~src_on[5];
   assign external_pin_a_n = ~src_on[6];
   // core takes each new request on the next clock edge with a one-cycle pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_r <= 20'h00000;
         arb_ack <= 20'h00000;
      end else begin
         seen_r <= arb_req;
         arb_ack <= arb_req & ~seen_r;
      end
   end
endmodule : iprl_src_model
`default_nettype wire

// File: verif/testbench.sv
// apb driven test of the priority level registers and request gating
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import iprl_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [17:0] periph_req;
   logic pin_a_n, pin_b_n, low_power_mode, wake_req;
   logic [19:0] arb_req, arb_ack, src_on;
   logic [39:0] arb_level;
   int errors, n_compared, r;
   int lsb_tab [20] = '{14, 12, 10, 8, 6, 2, 0, 14, 12, 10, 8, 6, 4, 2,
      14, 12, 10, 4, 2, 0};
   logic [11:0] addr_tab [3] = '{12'h008, 12'h00C, 12'h010};
   logic [15:0] mask_tab [3] = '{16'hFFCF, 16'hFFFC, 16'hFC3F};

   ////////////////////////////////////////////////////////////////////////
   iprl_regs #(.APB_AW(12)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .periph_req(periph_req),
      .external_pin_a_n(pin_a_n), .external_pin_b_n(pin_b_n),
      .low_power_mode(low_power_mode), .wake_req(wake_req),
      .arb_req(arb_req), .arb_level(arb_level), .arb_ack(arb_ack));
   iprl_src_model far (.pclk(pclk), .presetn(presetn), .src_on(src_on),
      .periph_req(periph_req), .external_pin_a_n(pin_a_n),
      .external_pin_b_n(pin_b_n), .arb_req(arb_req), .arb_ack(arb_ack));

   ////////////////////////////////////////////////////////////////////////
   // comparison and verdict
   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask : check

   task automatic end_of_test;
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test

   // one apb transfer, then an idle cycle so calls never collide
   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] d, input logic [3:0] s);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         errors++;
         end_of_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   ////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   initial begin
      {psel, penable, pwrite, low_power_mode} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hF;
      src_on = 20'h00000;
      errors = 0;
      n_compared = 0;
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // reset values, then all ones with reserved bits held clear
      for (int k = 0; k < 3; k++) begin
         apb(1'b0, addr_tab[k], 32'h0, 4'hF);
         check(40'(rd), 40'h0);
         apb(1'b1, addr_tab[k], 32'hFFFFFFFF, 4'hF);
         apb(1'b0, addr_tab[k], 32'h0, 4'hF);
         check(40'(rd), 40'(mask_tab[k]));
      end
      // only the upper lane written: lower byte keeps its ones
      apb(1'b1, addr_tab[1], 32'h0, 4'h2);
      apb(1'b0, addr_tab[1], 32'h0, 4'hF);
      check(40'(rd), 40'h00FC);
      $display("test register access done");
      // unmapped and misaligned words are refused and read zero
      apb(1'b0, 12'h014, 32'h0, 4'hF);
      check(40'({err, rd}), 40'h100000000);
      apb(1'b0, 12'h009, 32'h0, 4'hF);
      check(40'({err, rd}), 40'h100000000);
      $display("test unmapped done");
      // each source alone at each level, every source requesting
      for (int k = 0; k < 3; k++) apb(1'b1, addr_tab[k], 32'h0, 4'hF);
      src_on <= 20'hFFFFF;
      repeat (5) @(posedge pclk);
      check(40'(arb_req), 40'h0);
      for (int i = 0; i < 20; i++) begin
         r = i < 7 ? 0 : (i < 14 ? 1 : 2);
         for (int v = 1; v < 4; v++) begin
            apb(1'b1, addr_tab[r], 32'(v) << lsb_tab[i], 4'hF);
            check(40'(arb_req), 40'h1 << i);
            check(arb_level, 40'(v - 1) << (2 * i));
         end
         apb(1'b1, addr_tab[r], 32'h0, 4'hF);
      end
      check(40'(arb_req), 40'h0);
      $display("test field mapping done");
      // wake: pin a enabled and set to edge mode before low power
      apb(1'b1, 12'h080, 32'h1, 4'hF);
      apb(1'b1, addr_tab[0], 32'h1, 4'hF);
      src_on <= 20'h00000;
      low_power_mode <= 1'b1;
      repeat (2) @(posedge pclk);
      apb(1'b1, addr_tab[0], 32'h4001, 4'hF);
      src_on <= 20'h00001;
      @(posedge pclk);
      @(posedge pclk);
      check(40'(wake_req), 40'h0);
      src_on <= 20'h00041;
      @(posedge pclk);
      @(posedge pclk);
      check(40'(wake_req), 40'h1);
      @(posedge pclk);
      check(40'(wake_req), 40'h1);
      // long enough that a wrongly kept edge latch would be acked away
      repeat (5) @(posedge pclk);
      check(40'(arb_req), 40'h41);
      low_power_mode <= 1'b0;
      src_on <= 20'h00000;
      $display("test wake done");
      // edge mode when running: one request, taken back by the ack
      repeat (6) @(posedge pclk);
      src_on <= 20'h00040;
      repeat (5) @(posedge pclk);
      check(40'(arb_req), 40'h40);
      repeat (2) @(posedge pclk);
      check(40'(arb_req), 40'h0);
      src_on <= 20'h00000;
      $display("test edge mode done");
      // reset in mid run clears the second register's fields again
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, addr_tab[0], 32'h0, 4'hF);
      check(40'(rd), 40'h0);
      check(40'(arb_req), 40'h0);
      $display("test second reset done");
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
